// [design/bld_pkg.sv]
// Constants and types for the backlight dimming and lockout block
package bld_pkg;
  localparam int unsigned CLK_PERIOD_NS = 10;
  // Pin timing, in ns as specified
  localparam int unsigned T_ON_NS = 100_000;
  localparam int unsigned T_OFF_NS = 2_000_000;
  localparam int unsigned T_DIM_MIN_NS = 500;
  localparam int unsigned T_DIM_MAX_NS = 500_000;
  localparam int unsigned T_RST_NS = 200_000_000;
  // Least times round up, longest times round down
  localparam int unsigned ON_CYC = (T_ON_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned OFF_CYC = (T_OFF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned DIM_MIN_CYC = (T_DIM_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned DIM_MAX_CYC = T_DIM_MAX_NS / CLK_PERIOD_NS;
  localparam int unsigned RST_CYC = (T_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RUN_W = 18;
  localparam int unsigned RST_W = 25;
  // Feedback reference: 32 linear steps, top code is full scale
  localparam int unsigned LEVEL_W = 5;
  localparam logic [LEVEL_W-1:0] LEVEL_FULL = 5'h1f;
  localparam logic [LEVEL_W-1:0] LEVEL_MIN = 5'h00;
  // Register map
  localparam int unsigned ADDR_W = 8;
  localparam logic [ADDR_W-1:0] CTRL_ADDR = 8'h00;
  localparam logic [ADDR_W-1:0] STATUS_ADDR = 8'h04;
  localparam int unsigned BUCK_N = 3;
  localparam int unsigned CTRL_W = 4;
  localparam int unsigned CTRL_CHG_BIT = 0;
  localparam int unsigned CTRL_BUCK_LSB = 1;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 4'he;
  localparam int unsigned ST_LEVEL_LSB = 0;
  localparam int unsigned ST_BOOST_BIT = 5;
  localparam int unsigned ST_OVP_BIT = 6;
  localparam int unsigned ST_AUV_BIT = 7;
  localparam int unsigned ST_AOV_BIT = 8;
  localparam int unsigned ST_RUV_BIT = 9;
  localparam int unsigned ST_RSTREL_BIT = 10;

  typedef enum logic [2:0] {
    BL_OFF = 3'b001,
    BL_ON = 3'b010,
    BL_OVP = 3'b100
  } bld_bl_state_t;

  typedef struct packed {
    logic boost_ovp;
    logic adapter_uv;
    logic adapter_ov;
    logic rail_uv;
    logic reg_one_fb_ok;
    logic charging;
  } bld_sense_t;

  typedef struct packed {
    logic boost_en;
    logic led_sink_en;
    logic [BUCK_N-1:0] buck_en;
    logic adapter_connect;
    logic battery_connect;
    logic charger_en;
  } bld_power_t;
endpackage : bld_pkg

// [design/bld_run_timer.sv]
// Run-length timer: how long the control pin has held its level
`timescale 1ns/1ns
module bld_run_timer #(
  parameter int unsigned W = bld_pkg::RUN_W
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic level_in,
  output logic level_q,
  output logic [W-1:0] run_q
);
  import bld_pkg::*;

  logic [W-1:0] run_d;

  // Saturates so a pin parked for ages still reads as long
  always_comb
  begin
    run_d = run_q;
    if (level_in != level_q)
    begin
      run_d = '0;
    end
    else if (run_q != '1)
    begin
      run_d = run_q + 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      level_q <= 1'b0;
      run_q <= '0;
    end
    else
    begin
      level_q <= level_in;
      run_q <= run_d;
    end
  end
endmodule : bld_run_timer

// [design/bld_reset_delay.sv]
// Reset output for the first buck regulator with release delay
`timescale 1ns/1ns
module bld_reset_delay #(
  parameter int unsigned DLY = bld_pkg::RST_CYC,
  parameter int unsigned W = bld_pkg::RST_W
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic fb_ok,
  output logic hold_q
);
  import bld_pkg::*;

  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;
  logic hold_d;

  always_comb
  begin
    cnt_d = cnt_q;
    hold_d = hold_q;
    if (!fb_ok)
    begin
      cnt_d = '0; // RQ14
      hold_d = 1'b1; // RQ13
    end
    else if (cnt_q >= W'(DLY - 1))
    begin
      hold_d = 1'b0; // RQ14
    end
    else
    begin
      cnt_d = cnt_q + 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cnt_q <= '0;
      hold_q <= 1'b1;
    end
    else
    begin
      cnt_q <= cnt_d;
      hold_q <= hold_d;
    end
  end
endmodule : bld_reset_delay

// [design/bld_top.sv]
// Backlight pin decoder, boost latch, supply lockout and APB registers
//
// The APB slave port and the register addresses were left to the implementer.
`timescale 1ns/1ns
// Overview of operation
// [RQ1] Pin high 100us turns boost on at full 0.5V reference.
// [RQ2] Pin low 2ms turns boost off.
// [RQ3] Host dims with a low pulse of 500ns to 500us.
// [RQ4] Each valid dim pulse lowers LED current by 1/32.
// [RQ5] Reference has 32 linear steps; no pulses means plain on/off.
// [RQ6] Boost overvoltage latches boost off until pin low 2ms.
// [RQ7] Adapter undervoltage: disconnect adapter, charger off, indicator floats.
// [RQ8] Adapter undervoltage: battery feeds rail, regulators and sinks keep running.
// [RQ9] Adapter overvoltage: disconnect adapter, charger off, indicator floats.
// [RQ10] Adapter overvoltage: battery feeds rail, regulators keep running.
// [RQ11] Normal adapter use resumes once adapter is back in range.
// [RQ12] Rail undervoltage disables regulators, LED sinks and charger.
// [RQ13] Rail undervoltage floats indicator and asserts regulator one reset.
// [RQ14] Reset is open-drain low, released 200ms after feedback good.
// [RQ15] Too short lows ignored; over-long lows below 2ms change nothing.
// [RQ16] Level floors at lowest step, full scale on every power-up.
module bld_top #(
  parameter int unsigned ON_CYCLES = bld_pkg::ON_CYC,
  parameter int unsigned OFF_CYCLES = bld_pkg::OFF_CYC,
  parameter int unsigned DIM_MAX_CYCLES = bld_pkg::DIM_MAX_CYC,
  parameter int unsigned RESET_CYCLES = bld_pkg::RST_CYC
)
(
  input wire logic CLK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [bld_pkg::ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic BACKLIGHT_CTRL_PIN,
  input wire bld_pkg::bld_sense_t SENSE,
  output bld_pkg::bld_power_t POWER,
  output logic [bld_pkg::LEVEL_W-1:0] BOOST_FEEDBACK_REF,
  output logic CHARGE_IND_O,
  output logic CHARGE_IND_OE,
  output logic REG_ONE_RESET_N_O,
  output logic REG_ONE_RESET_N_OE
);
  import bld_pkg::*;

  // ==========================================================
  // Control pin timing
  logic pin_q;
  logic [RUN_W-1:0] run_q;
  logic rise;
  logic long_high;
  logic long_low;
  logic dim_ok;

  bld_run_timer #(
    .W(RUN_W)
  ) u_run (
    .clk(CLK),
    .rst(RST),
    .level_in(BACKLIGHT_CTRL_PIN),
    .level_q(pin_q),
    .run_q(run_q)
  );

  // On a rising edge the low just ended has lasted run_q + 1 cycles
  assign rise = BACKLIGHT_CTRL_PIN && !pin_q;
  assign long_high = pin_q && (run_q >= RUN_W'(ON_CYCLES - 1)); // RQ1
  assign long_low = !pin_q && (run_q >= RUN_W'(OFF_CYCLES - 1)); // RQ2
  assign dim_ok = rise && (run_q >= RUN_W'(DIM_MIN_CYC - 1))
    && (run_q <= RUN_W'(DIM_MAX_CYCLES - 1)); // RQ3 RQ15

  // ==========================================================
  // Boost state and dimming level
  bld_bl_state_t st_q;
  bld_bl_state_t st_d;
  logic [LEVEL_W-1:0] lvl_q;
  logic [LEVEL_W-1:0] lvl_d;

  always_comb
  begin
    st_d = st_q;
    lvl_d = lvl_q;
    case (st_q)
      BL_OFF:
      begin
        if (long_high)
        begin
          st_d = BL_ON; // RQ1
          lvl_d = LEVEL_FULL; // RQ16
        end
      end
      BL_ON:
      begin
        if (SENSE.boost_ovp)
        begin
          st_d = BL_OVP; // RQ6
        end
        else if (long_low)
        begin
          st_d = BL_OFF; // RQ2
        end
        else if (dim_ok && lvl_q != LEVEL_MIN)
        begin
          lvl_d = lvl_q - 1'b1; // RQ4 RQ5 RQ16
        end
      end
      BL_OVP:
      begin
        // Only a long low clears the latch; the pin's level alone does not
        if (long_low)
        begin
          st_d = BL_OFF; // RQ6
        end
      end
      default:
      begin
        st_d = BL_OFF;
      end
    endcase
  end

  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      st_q <= BL_OFF;
      lvl_q <= LEVEL_FULL;
    end
    else
    begin
      st_q <= st_d;
      lvl_q <= lvl_d;
    end
  end

  assign BOOST_FEEDBACK_REF = lvl_q; // RQ5

  // ==========================================================
  // Supply lockout
  logic [CTRL_W-1:0] ctrl_q;
  logic [CTRL_W-1:0] ctrl_d;
  logic adapter_ok;
  bld_power_t pwr_d;
  logic chg_oe_d;
  logic rst_hold;

  assign adapter_ok = !SENSE.adapter_uv && !SENSE.adapter_ov; // RQ11

  always_comb
  begin
    pwr_d.adapter_connect = adapter_ok; // RQ7 RQ9 RQ11
    pwr_d.battery_connect = !adapter_ok; // RQ8 RQ10
    // Regulators survive adapter lockout but not a sagging rail
    pwr_d.buck_en = SENSE.rail_uv ? '0 : ctrl_q[CTRL_BUCK_LSB +: BUCK_N]; // RQ12
    pwr_d.boost_en = (st_q == BL_ON) && !SENSE.rail_uv; // RQ6 RQ12
    pwr_d.led_sink_en = (st_q == BL_ON) && !SENSE.rail_uv; // RQ8 RQ12
    pwr_d.charger_en = adapter_ok && !SENSE.rail_uv && ctrl_q[CTRL_CHG_BIT]; // RQ7 RQ9 RQ12
    chg_oe_d = pwr_d.charger_en && SENSE.charging; // RQ7 RQ9 RQ13
  end

  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      POWER <= '0;
      CHARGE_IND_OE <= 1'b0;
    end
    else
    begin
      POWER <= pwr_d;
      CHARGE_IND_OE <= chg_oe_d;
    end
  end

  assign CHARGE_IND_O = 1'b0;

  bld_reset_delay #(
    .DLY(RESET_CYCLES),
    .W(RST_W)
  ) u_rst (
    .clk(CLK),
    .rst(RST),
    .fb_ok(SENSE.reg_one_fb_ok && ctrl_q[CTRL_BUCK_LSB] && !SENSE.rail_uv), // RQ13
    .hold_q(rst_hold)
  );

  // Open drain: only ever pulls low
  assign REG_ONE_RESET_N_O = 1'b0; // RQ14
  assign REG_ONE_RESET_N_OE = rst_hold; // RQ14

  // ==========================================================
  // APB slave, zero wait states
  logic setup;
  logic access;
  logic hit_ctrl;
  logic hit_stat;
  logic [31:0] status;
  logic [31:0] rdata_d;

  assign setup = PSEL && !PENABLE;
  assign access = PSEL && PENABLE;
  assign PREADY = 1'b1;

  always_comb
  begin
    hit_ctrl = 1'b0;
    hit_stat = 1'b0;
    if (PADDR == CTRL_ADDR)
    begin
      hit_ctrl = 1'b1;
    end
    else if (PADDR == STATUS_ADDR)
    begin
      hit_stat = 1'b1;
    end
  end

  assign PSLVERR = access && !hit_ctrl && !hit_stat;

  always_comb
  begin
    status = '0;
    status[ST_LEVEL_LSB +: LEVEL_W] = lvl_q;
    status[ST_BOOST_BIT] = (st_q == BL_ON);
    status[ST_OVP_BIT] = (st_q == BL_OVP);
    status[ST_AUV_BIT] = SENSE.adapter_uv;
    status[ST_AOV_BIT] = SENSE.adapter_ov;
    status[ST_RUV_BIT] = SENSE.rail_uv;
    status[ST_RSTREL_BIT] = !rst_hold;
  end

  always_comb
  begin
    ctrl_d = ctrl_q;
    rdata_d = PRDATA;
    if (access && PWRITE && hit_ctrl)
    begin
      ctrl_d = PWDATA[CTRL_W-1:0];
    end
    // Read data is caught in setup so it is a flop in the access phase
    if (setup)
    begin
      if (hit_ctrl)
      begin
        rdata_d = {{(32 - CTRL_W){1'b0}}, ctrl_q};
      end
      else if (hit_stat)
      begin
        rdata_d = status;
      end
      else
      begin
        rdata_d = '0;
      end
    end
  end

  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      ctrl_q <= CTRL_RESET;
      PRDATA <= '0;
    end
    else
    begin
      ctrl_q <= ctrl_d;
      PRDATA <= rdata_d;
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RST);

  power_up_level_a: assert property ( // RQ1
    st_q == BL_OFF && long_high |=> st_q == BL_ON && lvl_q == LEVEL_FULL)
    else $error("boost did not power up at full scale");

  power_down_a: assert property ( // RQ2
    st_q == BL_ON && long_low && !SENSE.boost_ovp |=> st_q == BL_OFF ##1 !POWER.boost_en)
    else $error("long low did not disable boost");

  dim_step_a: assert property ( // RQ4
    st_q == BL_ON && dim_ok && lvl_q != LEVEL_MIN && !SENSE.boost_ovp
    |=> lvl_q == $past(lvl_q) - 1'b1)
    else $error("valid pulse did not lower level by one");

  dim_floor_a: assert property ( // RQ16
    lvl_q == LEVEL_MIN && st_q == BL_ON |=> lvl_q == LEVEL_MIN || st_q != BL_ON)
    else $error("level wrapped below lowest step");

  level_hold_a: assert property ( // RQ5
    st_q != BL_OFF && !dim_ok |=> $stable(lvl_q))
    else $error("level moved without a dim pulse");

  bad_width_a: assert property ( // RQ15
    rise && !dim_ok |=> $stable(lvl_q) || $past(st_q) == BL_OFF)
    else $error("out-of-range low changed the level");

  ovp_latch_a: assert property ( // RQ6
    st_q == BL_ON && SENSE.boost_ovp |=> st_q == BL_OVP ##1 !POWER.boost_en)
    else $error("overvoltage did not latch boost off");

  ovp_hold_a: assert property ( // RQ6
    st_q == BL_OVP && !long_low |=> st_q == BL_OVP)
    else $error("overvoltage latch cleared early");

  adapter_lock_a: assert property ( // RQ7
    !adapter_ok |=> !POWER.adapter_connect && POWER.battery_connect
    && !POWER.charger_en && !CHARGE_IND_OE)
    else $error("adapter lockout not applied");

  lock_run_a: assert property ( // RQ8
    !adapter_ok && !SENSE.rail_uv
    |=> POWER.buck_en == $past(ctrl_q[CTRL_BUCK_LSB +: BUCK_N]))
    else $error("regulators stopped in adapter lockout");

  // The first edge out of reset still sees reset values on the registered outputs
  adapter_resume_a: assert property ( // RQ11
    adapter_ok && !$past(RST) |=> POWER.adapter_connect && !POWER.battery_connect)
    else $error("adapter not reconnected");

  rail_lock_a: assert property ( // RQ12
    SENSE.rail_uv |=> POWER.buck_en == '0 && !POWER.led_sink_en && !POWER.boost_en
    && !POWER.charger_en && !CHARGE_IND_OE && REG_ONE_RESET_N_OE)
    else $error("rail lockout not applied");

  reset_release_a: assert property ( // RQ14
    $fell(REG_ONE_RESET_N_OE) |-> $past(SENSE.reg_one_fb_ok) && !$past(SENSE.rail_uv))
    else $error("reset released without good feedback");

  cv_power_up: cover property (st_q == BL_OFF ##1 st_q == BL_ON);
  cv_dim_step: cover property (st_q == BL_ON && dim_ok);
  cv_ovp: cover property (st_q == BL_ON ##1 st_q == BL_OVP);
  cv_status_read: cover property (access && !PWRITE && hit_stat);
endmodule : bld_top

// [test/bld_host_model.sv]
// Host model that drives the backlight control pin
`timescale 1ns/1ns
module bld_host_model
(
  input wire logic clk,
  output logic pin
);
  initial pin = 1'b0;

  // Hold a level for an exact number of sampled edges
  task automatic hold(input logic lvl, input int n);
    @(posedge clk);
    pin <= lvl;
    repeat (n - 1) @(posedge clk);
  endtask : hold

  // One step request: a low of l edges, then back high
  task automatic dim(input int l);
    hold(1'b0, l);
    hold(1'b1, 5);
  endtask : dim
endmodule : bld_host_model

// [test/bld_top_tb.sv]
// Self-checking bench for the backlight dimming and lockout block
`timescale 1ns/1ns
module bld_top_tb;
  import bld_pkg::*;
  localparam int ON_C = 20;
  localparam int OFF_C = 200;
  localparam int DIM_M = 100;
  localparam int RST_C = 30;
  // Whole run needs well under 15000 cycles
  localparam int CYC_MAX = 40000;
  logic CLK, RST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, er, pin;
  logic ind_o, ind_oe, rst_n_o, rst_n_oe;
  logic [ADDR_W-1:0] PADDR;
  logic [31:0] PWDATA, PRDATA, rd;
  logic [LEVEL_W-1:0] ref_code;
  bld_sense_t sense;
  bld_power_t power;
  int n_fail = 0;
  int cmp_count = 0;
  int cyc = 0;

  bld_top #(.ON_CYCLES(ON_C), .OFF_CYCLES(OFF_C), .DIM_MAX_CYCLES(DIM_M),
    .RESET_CYCLES(RST_C)) i_dut (.CLK(CLK), .RST(RST), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
    .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .BACKLIGHT_CTRL_PIN(pin), .SENSE(sense), .POWER(power),
    .BOOST_FEEDBACK_REF(ref_code), .CHARGE_IND_O(ind_o), .CHARGE_IND_OE(ind_oe),
    .REG_ONE_RESET_N_O(rst_n_o), .REG_ONE_RESET_N_OE(rst_n_oe));

  bld_host_model i_host (.clk(CLK), .pin(pin));

  // ====================
  // Tasks
  initial
  begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] wd);
    @(posedge CLK);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= wr;
    PADDR <= a;
    PWDATA <= wd;
    @(posedge CLK);
    PENABLE <= 1'b1;
    @(posedge CLK);
    while (PREADY !== 1'b1) @(posedge CLK);
    rd = PRDATA;
    er = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask : apb

  task automatic settle();
    repeat (3) @(posedge CLK);
    #1;
  endtask : settle

  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : conclude

  always @(posedge CLK)
  begin
    cyc++;
    if (cyc == CYC_MAX)
    begin
      n_fail++;
      conclude();
    end
  end

  // ====================
  // Main sequence
  initial
  begin
    RST = 1'b1;
    PSEL = 1'b0;
    PENABLE = 1'b0;
    PWRITE = 1'b0;
    PADDR = '0;
    PWDATA = '0;
    sense = '0;
    sense.reg_one_fb_ok = 1'b1;
    repeat (10) @(posedge CLK);
    chk("ref at reset", ref_code, LEVEL_FULL);
    chk("power at reset", power, '0);
    chk("reg_one_reset_n at reset", rst_n_oe, 1'b1);
    RST <= 1'b0;
    repeat (RST_C - 1) @(posedge CLK);
    #1 chk("reg_one_reset_n held", rst_n_oe, 1'b1);
    repeat (1) @(posedge CLK);
    #1 chk("reg_one_reset_n freed", rst_n_oe, 1'b0);
    chk("reg_one_reset_n pin", rst_n_o, 1'b0);
    apb(1'b0, CTRL_ADDR, '0);
    chk("ctrl reset", rd, CTRL_RESET);
    apb(1'b1, CTRL_ADDR, 32'hffff_ffff);
    apb(1'b0, CTRL_ADDR, '0);
    chk("ctrl rw", rd, 32'h0000_000f);
    apb(1'b1, STATUS_ADDR, '0);
    chk("status wr err", er, 1'b0);
    apb(1'b0, STATUS_ADDR, '0);
    chk("status", rd, 32'h0000_041f);
    apb(1'b1, 8'h08, 32'h0000_0001);
    chk("unmapped wr", er, 1'b1);
    apb(1'b0, 8'h08, '0);
    chk("unmapped rd", {rd[30:0], er}, 32'h0000_0001);
    i_host.hold(1'b1, ON_C + 1);
    #1 chk("not on yet", power.boost_en, 1'b0);
    i_host.hold(1'b1, 2);
    #1 chk("boost on", power.boost_en, 1'b1);
    chk("full ref", ref_code, LEVEL_FULL);
    i_host.dim(DIM_MIN_CYC);
    #1 chk("dim min", ref_code, 5'h1e);
    i_host.dim(DIM_M);
    #1 chk("dim max", ref_code, 5'h1d);
    i_host.dim(DIM_MIN_CYC - 1);
    i_host.dim(DIM_M + 1);
    #1 chk("bad widths", ref_code, 5'h1d);
    repeat (30) i_host.dim(DIM_MIN_CYC);
    #1 chk("floor", ref_code, LEVEL_MIN);
    apb(1'b0, STATUS_ADDR, '0);
    chk("level status", rd[5:0], 6'h20);
    i_host.hold(1'b0, OFF_C + 20);
    #1 chk("boost off", power.boost_en, 1'b0);
    i_host.hold(1'b1, ON_C + 10);
    #1 chk("boost again", power.boost_en, 1'b1);
    chk("ref restored", ref_code, LEVEL_FULL);
    @(posedge CLK);
    sense.boost_ovp <= 1'b1;
    settle();
    chk("ovp trip", power.boost_en, 1'b0);
    @(posedge CLK);
    sense.boost_ovp <= 1'b0;
    i_host.hold(1'b0, DIM_M + 1);
    i_host.hold(1'b1, ON_C + 10);
    #1 chk("ovp latched", power.boost_en, 1'b0);
    apb(1'b0, STATUS_ADDR, '0);
    chk("ovp status", rd[6:5], 2'h2);
    i_host.hold(1'b0, OFF_C + 20);
    i_host.hold(1'b1, ON_C + 10);
    #1 chk("ovp cleared", power.boost_en, 1'b1);
    @(posedge CLK);
    sense.charging <= 1'b1;
    settle();
    chk("indicator on", ind_oe, 1'b1);
    for (int i = 0; i < 2; i++)
    begin
      @(posedge CLK);
      sense.adapter_uv <= (i == 0);
      sense.adapter_ov <= (i == 1);
      settle();
      chk("adapter cut", power.adapter_connect, 1'b0);
      chk("battery feed", power.battery_connect, 1'b1);
      chk("charger off", power.charger_en, 1'b0);
      chk("indicator float", ind_oe, 1'b0);
      chk("bucks run", power.buck_en, 3'h7);
      chk("boost runs", power.boost_en, 1'b1);
      chk("sinks run", power.led_sink_en, 1'b1);
      @(posedge CLK);
      sense.adapter_uv <= 1'b0;
      sense.adapter_ov <= 1'b0;
      settle();
      chk("adapter back", power.adapter_connect, 1'b1);
      chk("charger back", power.charger_en, 1'b1);
    end
    @(posedge CLK);
    sense.rail_uv <= 1'b1;
    settle();
    chk("bucks off", power.buck_en, 3'h0);
    chk("sinks off", power.led_sink_en, 1'b0);
    chk("boost off uv", power.boost_en, 1'b0);
    chk("charger off uv", power.charger_en, 1'b0);
    chk("indicator uv", ind_oe, 1'b0);
    chk("indicator pin", ind_o, 1'b0);
    chk("reg_one_reset_n uv", rst_n_oe, 1'b1);
    conclude();
  end
endmodule : bld_top_tb
